/* File: shared/stbank_pkg.sv */
// constants for the self-test and i2c timing register bank
package stbank_pkg;
    // register offsets
    localparam logic [7:0] OFS_SELFTEST_CTRL = 8'h24;
    localparam logic [7:0] OFS_ERR_COUNT = 8'h25;
    localparam logic [7:0] OFS_SCL_HIGH = 8'h26;
    localparam logic [7:0] OFS_SCL_LOW = 8'h27;
    // remote serializer clock-source register
    localparam logic [7:0] OFS_REMOTE_CLKSRC = 8'h14;
    // reset values
    localparam logic [7:0] RST_SELFTEST_CTRL = 8'h08;
    localparam logic [7:0] RST_SCL_HIGH = 8'h83;
    localparam logic [7:0] RST_SCL_LOW = 8'h84;
    localparam logic [7:0] RST_DATA = 8'h00;
    // field positions in the self-test control register
    localparam int BIT_EN = 0;
    localparam int BIT_SRC_LO = 1;
    localparam int BIT_SRC_HI = 2;
    localparam int BIT_PIN_CFG = 3;
    localparam int BIT_FREQ_LO = 4;
    localparam int BIT_FREQ_HI = 5;
    localparam int BIT_MODE_LO = 6;
    localparam int BIT_MODE_HI = 7;
    // output mode and frequency codes
    localparam logic [1:0] MODE_STEADY = 2'h0;
    localparam logic [1:0] MODE_ALT = 2'h1;
    localparam logic [1:0] FREQ_50 = 2'h0;
    localparam logic [1:0] FREQ_25 = 2'h1;
    localparam logic [1:0] FREQ_10 = 2'h2;
    localparam logic [5:0] MHZ_50 = 6'h32;
    localparam logic [5:0] MHZ_25 = 6'h19;
    localparam logic [5:0] MHZ_10 = 6'h0a;
    localparam logic [5:0] MHZ_NONE = 6'h00;
    localparam logic [1:0] SRC_EXTERNAL = 2'h0;
    // clock source used while the pin governs self-test
    localparam logic [1:0] PIN_CLK_SRC = 2'h0;
    // timing: one count unit is 50 ns, clock is 10 ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int UNIT_NS = 50;
    localparam int UNIT_CYCLES_INT = (UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] UNIT_CYCLES = 3'(UNIT_CYCLES_INT);
    localparam logic [2:0] PRE_LAST = 3'(UNIT_CYCLES_INT - 1);
    // slow oscillator margin for default counts
    localparam int MIN_SCL_NS = 5000;
    localparam int NOM_OSC_MHZ = 20;
    localparam int SLOW_OSC_MHZ = 26;
endpackage

/* File: verilog/stbank_scl_timer.sv */
// scl high/low pulse timer and slave sda setup interval
`timescale 1ns/100ps
`default_nettype none
module stbank_scl_timer
    import stbank_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // programmed counts
    input wire logic [7:0] high_time,
    input wire logic [7:0] low_time,
    // requests
    input wire logic master_run,
    input wire logic setup_start,
    // results
    output logic scl_drive_low,
    output logic setup_done
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HIGH = 2'b01,
        ST_LOW = 2'b10,
        ST_SETUP = 2'b11
    } stbank_tmr_e;

    stbank_tmr_e state, next_state;
    logic [2:0] pre;
    logic [7:0] unit;
    logic done_q;

    // a zero count still gives one unit
    function automatic logic [7:0] last_unit(input logic [7:0] t);
        last_unit = (t == 8'h00) ? 8'h00 : t - 8'h01;
    endfunction

    wire logic tick_end = (pre == PRE_LAST);
    wire logic hi_end = tick_end && (unit == last_unit(high_time));
    wire logic lo_end = tick_end && (unit == last_unit(low_time));

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (master_run) begin
                    next_state = ST_HIGH;
                end else if (setup_start) begin
                    next_state = ST_SETUP;
                end
            end
            ST_HIGH: begin
                if (hi_end) begin
                    next_state = master_run ? ST_LOW : ST_IDLE;
                end
            end
            ST_LOW: begin
                if (lo_end) begin
                    next_state = master_run ? ST_HIGH : ST_IDLE;
                end
            end
            ST_SETUP: begin
                if (lo_end) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    wire logic restart = (state != next_state) || (state == ST_IDLE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            pre <= 3'h0;
            unit <= 8'h00;
            done_q <= 1'b0;
        end else begin
            state <= next_state;
            pre <= (restart || tick_end) ? 3'h0 : pre + 3'h1;
            unit <= restart ? 8'h00 : (tick_end ? unit + 8'h01 : unit);
            done_q <= (state == ST_SETUP) && lo_end;
        end
    end

    assign scl_drive_low = (state == ST_LOW) || (state == ST_SETUP);
    assign setup_done = done_q;

    // length of each phase, for checking
    logic [11:0] run_len;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_len <= 12'h000;
        end else begin
            run_len <= (state != next_state) ? 12'h000 : run_len + 12'h001;
        end
    end

    property p_high_len;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_HIGH && next_state != ST_HIGH && $stable(high_time) && high_time != 8'h00)
            |-> (run_len + 12'h001 == 12'(high_time) * 12'(UNIT_CYCLES));
    endproperty
    a_high_len: assert property (p_high_len) else $error("scl high time wrong");

    property p_low_len;
        @(posedge clk) disable iff (!rst_n)
        (state == ST_LOW && next_state != ST_LOW && $stable(low_time) && low_time != 8'h00)
            |-> (run_len + 12'h001 == 12'(low_time) * 12'(UNIT_CYCLES));
    endproperty
    a_low_len: assert property (p_low_len) else $error("scl low time wrong");

    property p_setup_done;
        @(posedge clk) disable iff (!rst_n)
        $fell(scl_drive_low) && $past(state) == ST_SETUP |-> setup_done;
    endproperty
    a_setup_done: assert property (p_setup_done) else $error("setup release without done");

    c_master: cover property (@(posedge clk) disable iff (!rst_n) state == ST_LOW ##1 state == ST_HIGH);
    c_setup: cover property (@(posedge clk) disable iff (!rst_n) setup_done);
endmodule
`default_nettype wire

/* File: verilog/stbank_regs.sv */
// self-test control, error count and i2c scl timing register bank
`timescale 1ns/100ps
`default_nettype none
// Function
// - the output mode field picks steady, alternating or data-driven self-test output.
// - with automatic oscillator clocking on, the frequency field sets 50, 25 or 10 MHz, 11 reserved.
// - bit 3 set means the pin governs self-test, cleared means bits 2:0 govern.
// - when self-test becomes enabled the clock source field is sent to the remote clock-source register, or PIN_CLK_SRC while bit 3 is set.
// - bit 0 enables self-test and resets to disabled.
// - the read-only error count shows port 1 when bit 0 of the port-select field is set, else port 0.
// - as local i2c master, scl is held high for the high count in 50 ns units, reset 0x83.
// - as local i2c master, scl is held low for the low count in 50 ns units, reset 0x84.
// - as slave on channel accesses, the low count is the sda setup time before releasing scl.
// - the default counts give at least 5 us even with a 26 MHz oscillator.
module stbank_regs
    import stbank_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // register access
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // self-test pin, data and status
    input wire logic SELFTEST_PIN,
    input wire logic SELFTEST_DATA,
    output logic SELFTEST_EN,
    output logic SELFTEST_OUT,
    // oscillator receive clock
    input wire logic AUTO_CLOCK_EN,
    output logic [5:0] OSC_RX_FREQ_MHZ,
    // remote clock-source write
    output logic REMOTE_WR,
    output logic [7:0] REMOTE_ADDR,
    output logic [1:0] REMOTE_CLKSRC,
    output logic REMOTE_CLK_INTERNAL,
    // error counters and port select
    input wire logic [1:0] PORT_SEL,
    input wire logic [7:0] ERR_COUNT_P0,
    input wire logic [7:0] ERR_COUNT_P1,
    // local i2c
    input wire logic MASTER_RUN,
    input wire logic SETUP_START,
    output logic SCL_O,
    output logic SCL_OE,
    output logic SETUP_DONE
);
    logic rst_meta, rst_n;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    logic [7:0] ctrl, scl_high, scl_low, rdata;
    logic en_q, out_q, rwr_q;
    logic [1:0] rsrc_q;
    logic [5:0] mhz_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    wire logic wr_ctrl = REG_WR && hit(REG_ADDR, OFS_SELFTEST_CTRL);
    wire logic wr_high = REG_WR && hit(REG_ADDR, OFS_SCL_HIGH);
    wire logic wr_low = REG_WR && hit(REG_ADDR, OFS_SCL_LOW);

    wire logic [1:0] out_mode = ctrl[BIT_MODE_HI:BIT_MODE_LO];
    wire logic [1:0] freq_sel = ctrl[BIT_FREQ_HI:BIT_FREQ_LO];
    wire logic pin_cfg = ctrl[BIT_PIN_CFG];
    wire logic eff_en = pin_cfg ? SELFTEST_PIN : ctrl[BIT_EN];
    wire logic [1:0] eff_src = pin_cfg ? PIN_CLK_SRC : ctrl[BIT_SRC_HI:BIT_SRC_LO];
    wire logic en_rise = eff_en && !en_q;

    wire logic [7:0] sel_count = PORT_SEL[0] ? ERR_COUNT_P1 : ERR_COUNT_P0;

    wire logic [7:0] next_rdata =
        hit(REG_ADDR, OFS_SELFTEST_CTRL) ? ctrl :
        hit(REG_ADDR, OFS_ERR_COUNT) ? sel_count :
        hit(REG_ADDR, OFS_SCL_HIGH) ? scl_high :
        hit(REG_ADDR, OFS_SCL_LOW) ? scl_low : RST_DATA;

    wire logic [5:0] next_mhz =
        !AUTO_CLOCK_EN ? MHZ_NONE :
        (freq_sel == FREQ_50) ? MHZ_50 :
        (freq_sel == FREQ_25) ? MHZ_25 :
        (freq_sel == FREQ_10) ? MHZ_10 : MHZ_NONE;

    wire logic next_out =
        !eff_en ? 1'b0 :
        (out_mode == MODE_STEADY) ? out_q :
        (out_mode == MODE_ALT) ? !out_q : SELFTEST_DATA;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= RST_SELFTEST_CTRL;
            scl_high <= RST_SCL_HIGH;
            scl_low <= RST_SCL_LOW;
            rdata <= RST_DATA;
        end else begin
            ctrl <= wr_ctrl ? REG_WDATA : ctrl;
            scl_high <= wr_high ? REG_WDATA : scl_high;
            scl_low <= wr_low ? REG_WDATA : scl_low;
            rdata <= REG_RD ? next_rdata : rdata;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
            out_q <= 1'b0;
            rwr_q <= 1'b0;
            rsrc_q <= SRC_EXTERNAL;
            mhz_q <= MHZ_NONE;
        end else begin
            en_q <= eff_en;
            out_q <= next_out;
            rwr_q <= en_rise;
            rsrc_q <= en_rise ? eff_src : rsrc_q;
            mhz_q <= next_mhz;
        end
    end

    // counts untouched since reset, for the margin check
    logic timing_default;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            timing_default <= 1'b1;
        end else begin
            timing_default <= timing_default && !wr_high && !wr_low;
        end
    end

    logic drive_low;
    stbank_scl_timer u_timer (
        .clk(CLK),
        .rst_n(rst_n),
        .high_time(scl_high),
        .low_time(scl_low),
        .master_run(MASTER_RUN),
        .setup_start(SETUP_START),
        .scl_drive_low(drive_low),
        .setup_done(SETUP_DONE)
    );

    assign REG_RDATA = rdata;
    assign SELFTEST_EN = en_q;
    assign SELFTEST_OUT = out_q;
    assign OSC_RX_FREQ_MHZ = mhz_q;
    assign REMOTE_WR = rwr_q;
    assign REMOTE_ADDR = OFS_REMOTE_CLKSRC;
    assign REMOTE_CLKSRC = rsrc_q;
    assign REMOTE_CLK_INTERNAL = (rsrc_q != SRC_EXTERNAL);
    assign SCL_O = 1'b0;
    assign SCL_OE = drive_low;

    property p_mode_alt;
        @(posedge CLK) disable iff (!rst_n)
        (eff_en && out_mode == MODE_ALT) ##1 (eff_en && out_mode == MODE_ALT)
            |=> SELFTEST_OUT != $past(SELFTEST_OUT);
    endproperty
    a_mode_alt: assert property (p_mode_alt) else $error("alternating output stuck");

    property p_mode_steady;
        @(posedge CLK) disable iff (!rst_n)
        (eff_en && out_mode == MODE_STEADY) |=> $stable(SELFTEST_OUT);
    endproperty
    a_mode_steady: assert property (p_mode_steady) else $error("steady output moved");

    property p_freq;
        @(posedge CLK) disable iff (!rst_n)
        (AUTO_CLOCK_EN && freq_sel == FREQ_25) |=> OSC_RX_FREQ_MHZ == MHZ_25;
    endproperty
    a_freq: assert property (p_freq) else $error("oscillator frequency code wrong");

    property p_pin_cfg;
        @(posedge CLK) disable iff (!rst_n)
        pin_cfg |=> SELFTEST_EN == $past(SELFTEST_PIN);
    endproperty
    a_pin_cfg: assert property (p_pin_cfg) else $error("pin does not govern self-test");

    property p_remote;
        @(posedge CLK) disable iff (!rst_n)
        $rose(SELFTEST_EN) |-> REMOTE_WR && REMOTE_CLKSRC == $past(eff_src);
    endproperty
    a_remote: assert property (p_remote) else $error("clock source not sent on enable");

    property p_enable;
        @(posedge CLK) disable iff (!rst_n)
        (wr_ctrl && !REG_WDATA[BIT_PIN_CFG]) |=> ##1 SELFTEST_EN == $past(REG_WDATA[BIT_EN], 2);
    endproperty
    a_enable: assert property (p_enable) else $error("enable bit not applied");

    property p_err_count;
        @(posedge CLK) disable iff (!rst_n)
        (REG_RD && hit(REG_ADDR, OFS_ERR_COUNT) && PORT_SEL[0])
            |=> REG_RDATA == $past(ERR_COUNT_P1);
    endproperty
    a_err_count: assert property (p_err_count) else $error("error count port wrong");

    property p_default_margin;
        @(posedge CLK) disable iff (!rst_n)
        timing_default |-> (int'(scl_high) * UNIT_NS * NOM_OSC_MHZ >= MIN_SCL_NS * SLOW_OSC_MHZ)
            && (int'(scl_low) * UNIT_NS * NOM_OSC_MHZ >= MIN_SCL_NS * SLOW_OSC_MHZ);
    endproperty
    a_default_margin: assert property (p_default_margin) else $error("default counts too short");

    c_remote: cover property (@(posedge CLK) disable iff (!rst_n) REMOTE_WR && REMOTE_CLK_INTERNAL);
    c_data_mode: cover property (@(posedge CLK) disable iff (!rst_n) SELFTEST_EN && out_mode[1]);
    c_read_cnt: cover property (@(posedge CLK) disable iff (!rst_n) REG_RD && hit(REG_ADDR, OFS_ERR_COUNT));
endmodule
`default_nettype wire

/* File: testbench/stbank_far_model.sv */
// far-side model: remote clock-source register and pulled-up local scl line
`timescale 1ns/100ps
`default_nettype none
module stbank_far_model
    import stbank_pkg::*;
(
    // clock
    input wire logic clk,
    // remote register write from the device
    input wire logic remote_wr,
    input wire logic [7:0] remote_addr,
    input wire logic [1:0] remote_clksrc,
    // local scl, open drain
    input wire logic scl_o,
    input wire logic scl_oe,
    output logic scl,
    // observations
    output logic [1:0] clk_source,
    output int n_writes,
    output int high_run,
    output int low_run
);
    logic prev = 1'b1;
    logic [1:0] src_q = 2'h3;
    int run = 0, writes = 0, hi_q = 0, lo_q = 0;
    // pull-up wins while nobody drives
    assign scl = scl_oe ? scl_o : 1'b1;
    assign clk_source = src_q;
    assign n_writes = writes;
    assign high_run = hi_q;
    assign low_run = lo_q;
    // remote serializer takes the clock-source write
    always @(posedge clk) begin
        if (remote_wr && remote_addr == OFS_REMOTE_CLKSRC) begin
            src_q <= remote_clksrc;
            writes <= writes + 1;
        end
    end
    // length of each scl level in clock cycles
    always @(posedge clk) begin
        if (scl != prev) begin
            if (prev) begin
                hi_q <= run;
            end else begin
                lo_q <= run;
            end
            run <= 1;
        end else begin
            run <= run + 1;
        end
        prev <= scl;
    end
endmodule
`default_nettype wire

/* File: testbench/selftest_and_i2c_timing_regs_tb_top.sv */
// testbench for the self-test and i2c timing register bank
`timescale 1ns/100ps
`default_nettype none
module selftest_and_i2c_timing_regs_tb_top
    import stbank_pkg::*;
;
    logic CLK = 1'b0, RSTN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, REMOTE_ADDR;
    logic SELFTEST_PIN = 1'b0, SELFTEST_DATA = 1'b0, AUTO_CLOCK_EN = 1'b0;
    logic MASTER_RUN = 1'b0, SETUP_START = 1'b0, SELFTEST_EN, SELFTEST_OUT;
    logic REMOTE_WR, REMOTE_CLK_INTERNAL, SCL_O, SCL_OE, SETUP_DONE, scl;
    logic [5:0] OSC_RX_FREQ_MHZ;
    logic [1:0] REMOTE_CLKSRC, far_src, PORT_SEL = 2'h0;
    logic [7:0] ERR_COUNT_P0 = 8'h11, ERR_COUNT_P1 = 8'h22;
    int far_writes, high_run, low_run, n_fail = 0, samples_checked = 0;

    stbank_regs dut (.CLK, .RSTN, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
        .SELFTEST_PIN, .SELFTEST_DATA, .SELFTEST_EN, .SELFTEST_OUT, .AUTO_CLOCK_EN,
        .OSC_RX_FREQ_MHZ, .REMOTE_WR, .REMOTE_ADDR, .REMOTE_CLKSRC, .REMOTE_CLK_INTERNAL,
        .PORT_SEL, .ERR_COUNT_P0, .ERR_COUNT_P1, .MASTER_RUN, .SETUP_START, .SCL_O,
        .SCL_OE, .SETUP_DONE);
    stbank_far_model far (.clk(CLK), .remote_wr(REMOTE_WR), .remote_addr(REMOTE_ADDR),
        .remote_clksrc(REMOTE_CLKSRC), .scl_o(SCL_O), .scl_oe(SCL_OE), .scl(scl),
        .clk_source(far_src), .n_writes(far_writes), .high_run(high_run),
        .low_run(low_run));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        check(name, REG_RDATA, exp);
    endtask
    task automatic t_reset();
        rd_chk(OFS_SELFTEST_CTRL, 8'h08, "ctrl reset");
        rd_chk(OFS_SCL_HIGH, 8'h83, "high reset");
        rd_chk(OFS_SCL_LOW, 8'h84, "low reset");
        check("enable reset", SELFTEST_EN, 1'b0);
        rd_chk(8'h30, 8'h00, "unmapped read");
        wr_reg(OFS_ERR_COUNT, 8'hff);
        for (int p = 0; p < 4; p++) begin
            @(posedge CLK);
            PORT_SEL <= 2'(p);
            rd_chk(OFS_ERR_COUNT, p[0] ? ERR_COUNT_P1 : ERR_COUNT_P0, "error count");
        end
    endtask
    task automatic t_enable();
        wr_reg(OFS_SELFTEST_CTRL, 8'h04);
        tick(3);
        check("enable off", SELFTEST_EN, 1'b0);
        wr_reg(OFS_SELFTEST_CTRL, 8'h05);
        tick(3);
        check("enable on", SELFTEST_EN, 1'b1);
        check("remote source", far_src, 2'h2);
        check("remote internal", REMOTE_CLK_INTERNAL, 1'b1);
        check("remote writes", 16'(far_writes), 16'h0001);
    endtask
    task automatic t_modes();
        logic a;
        wr_reg(OFS_SELFTEST_CTRL, 8'h41);
        tick(3);
        a = SELFTEST_OUT;
        tick(1);
        check("alternating", a ^ SELFTEST_OUT, 1'b1);
        wr_reg(OFS_SELFTEST_CTRL, 8'h01);
        tick(3);
        a = SELFTEST_OUT;
        tick(4);
        check("steady", SELFTEST_OUT, a);
        for (int m = 2; m < 4; m++) begin
            wr_reg(OFS_SELFTEST_CTRL, {2'(m), 6'h01});
            for (int d = 0; d < 2; d++) begin
                @(posedge CLK);
                SELFTEST_DATA <= d[0];
                tick(2);
                check("data driven", SELFTEST_OUT, d[0]);
            end
        end
    endtask
    task automatic t_pin();
        wr_reg(OFS_SELFTEST_CTRL, 8'h00);
        @(posedge CLK);
        SELFTEST_PIN <= 1'b1;
        wr_reg(OFS_SELFTEST_CTRL, 8'h08);
        tick(3);
        check("pin enable", SELFTEST_EN, 1'b1);
        check("pin source", far_src, PIN_CLK_SRC);
        check("pin internal", REMOTE_CLK_INTERNAL, 1'b0);
        check("pin writes", 16'(far_writes), 16'h0002);
        @(posedge CLK);
        SELFTEST_PIN <= 1'b0;
        tick(3);
        check("pin disable", SELFTEST_EN, 1'b0);
    endtask
    task automatic t_freq();
        logic [5:0] mhz [4] = '{MHZ_50, MHZ_25, MHZ_10, MHZ_NONE};
        @(posedge CLK);
        AUTO_CLOCK_EN <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            wr_reg(OFS_SELFTEST_CTRL, {2'h0, 2'(f), 4'h8});
            tick(2);
            check("rx clock mhz", OSC_RX_FREQ_MHZ, mhz[f]);
        end
        @(posedge CLK);
        AUTO_CLOCK_EN <= 1'b0;
        wr_reg(OFS_SELFTEST_CTRL, 8'h18);
        tick(2);
        check("rx clock off", OSC_RX_FREQ_MHZ, MHZ_NONE);
    endtask
    task automatic t_scl();
        wr_reg(OFS_SCL_HIGH, 8'h02);
        wr_reg(OFS_SCL_LOW, 8'h03);
        @(posedge CLK);
        MASTER_RUN <= 1'b1;
        tick(60);
        check("scl high", 16'(high_run), 16'(2 * UNIT_CYCLES_INT));
        check("scl low", 16'(low_run), 16'(3 * UNIT_CYCLES_INT));
        @(posedge CLK);
        MASTER_RUN <= 1'b0;
        tick(40);
        wr_reg(OFS_SCL_LOW, 8'h02);
        @(posedge CLK);
        SETUP_START <= 1'b1;
        @(posedge CLK);
        SETUP_START <= 1'b0;
        for (int n = 0; n < 100 && SETUP_DONE !== 1'b1; n++) tick(1);
        check("setup done", SETUP_DONE, 1'b1);
        if (SETUP_DONE !== 1'b1) test_done();
        check("scl released", SCL_OE, 1'b0);
        tick(1);
        check("setup low", 16'(low_run), 16'(2 * UNIT_CYCLES_INT));
    endtask

    initial begin
        forever #5 CLK = ~CLK;
    end
    initial begin
        repeat (2) @(posedge CLK);
        RSTN <= 1'b1;
        tick(3);
        t_reset();
        t_enable();
        t_modes();
        t_pin();
        t_freq();
        t_scl();
        test_done();
    end
endmodule
`default_nettype wire
